// >>> design/nmd_cfg.svh
// offsets, field positions, reset values and timing counts for the nand sequencer
// assumes the core clock runs at the rate given by NMD_CLK_NS
`ifndef NMD_CFG_SVH
`define NMD_CFG_SVH

`define NMD_CLK_NS 100
`define NMD_T_READ_NS 40000
`define NMD_T_MREAD_NS 55000
`define NMD_T_PROG_NS 330000
`define NMD_T_ERASE_NS 3500000
`define NMD_CYC(ns) (((ns) + `NMD_CLK_NS - 1) / `NMD_CLK_NS)
`define NMD_READ_CYC `NMD_CYC(`NMD_T_READ_NS)
`define NMD_MREAD_CYC `NMD_CYC(`NMD_T_MREAD_NS)
`define NMD_PROG_CYC `NMD_CYC(`NMD_T_PROG_NS)
`define NMD_ERASE_CYC `NMD_CYC(`NMD_T_ERASE_NS)

`define NMD_CMD_READ 8'h00
`define NMD_CMD_READ_GO 8'h30
`define NMD_CMD_LOAD 8'h80
`define NMD_CMD_LOAD2 8'h81
`define NMD_CMD_COLCHG 8'h85
`define NMD_CMD_PROG_GO 8'h10
`define NMD_CMD_PROG_HOLD 8'h11
`define NMD_CMD_SETUP 8'h60
`define NMD_CMD_ERASE_GO 8'hd0
`define NMD_CMD_STAT 8'h70
`define NMD_CMD_STAT_DIST 8'h71
`define NMD_CMD_RESET 8'hff

`define NMD_MAIN_BYTES 12'h800
`define NMD_PARITY_LO 12'h840
`define NMD_PARITY_HI 12'h87f
`define NMD_SECT_MAIN_SHIFT 9
`define NMD_SECT_SPARE_SHIFT 4
`define NMD_DIST_BIT 6
`define NMD_ECC_CORR_MAX 4'h8
`define NMD_ECC_DET_MAX 4'h9

`define NMD_ST_FAIL 0
`define NMD_ST_D0_FAIL 1
`define NMD_ST_D1_FAIL 2
`define NMD_ST_REWRITE 3
`define NMD_ST_READY_A 5
`define NMD_ST_READY_B 6
`define NMD_ST_WP 7

`define NMD_WB_CTRL 8'h00
`define NMD_WB_STATUS 8'h04
`define NMD_WB_ADDR 8'h08
`define NMD_WB_SECT 8'h0c
`define NMD_CTRL_RESET 32'h0000_0000
`define NMD_CTRL_FAIL_LSB 0
`define NMD_CTRL_ECC_LSB 8

`endif

// >>> design/nmd_pkg.sv
// types shared by the nand sequencer and its array engine
package nmd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_DATA = 3'h3,
		ST_BUSY = 3'h2,
		ST_WAIT2 = 3'h6
	} nmd_state_type;
	typedef enum logic [2:0] {
		MODE_NONE = 3'h0,
		MODE_READ = 3'h1,
		MODE_PROG = 3'h2,
		MODE_PROG2 = 3'h3,
		MODE_SETUP = 3'h4
	} nmd_mode_type;
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_PROG = 2'h1,
		OP_ERASE = 2'h2
	} nmd_op_type;
	typedef enum logic [1:0] {
		OUT_NONE = 2'h0,
		OUT_STAT = 2'h1,
		OUT_STAT_DIST = 2'h2,
		OUT_PAGE = 2'h3
	} nmd_out_type;
endpackage

// >>> design/nmd_eng_if.sv
// handshake between the command sequencer and the array engine
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface nmd_eng_if;
	logic start;
	logic abort;
	nmd_pkg::nmd_op_type op;
	logic multi;
	logic [1:0] dist_mask;
	logic [1:0] fail_inj;
	logic [3:0] ecc_errs;
	logic wp_ok;
	logic busy;
	logic done;
	logic [1:0] fail;
	logic ecc_uncorr;
	logic ecc_rewrite;
	modport seq (output start, abort, op, multi, dist_mask, fail_inj, ecc_errs, wp_ok,
		input busy, done, fail, ecc_uncorr, ecc_rewrite);
	modport eng (input start, abort, op, multi, dist_mask, fail_inj, ecc_errs, wp_ok,
		output busy, done, fail, ecc_uncorr, ecc_rewrite);
endinterface

// >>> design/nmd_engine.sv
// array engine: times read, program and erase busy periods and forms per-district results
// assumes start is a one-cycle pulse from the sequencer, never given while busy
`timescale 1ns/1ns
`include "nmd_cfg.svh"
module nmd_engine #(
	parameter logic [15:0] ERASE_CYCLES = 16'(`NMD_ERASE_CYC)
) (
	input wire logic i_clk,
	input wire logic i_rst,
	nmd_eng_if.eng eng
);
	logic [15:0] cnt_reg;
	nmd_pkg::nmd_op_type op_reg;
	logic [1:0] mask_reg;
	logic [1:0] inj_reg;
	logic [3:0] errs_reg;
	logic wp_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst || eng.abort) begin
			eng.busy <= 1'b0;
			cnt_reg <= 16'h0000;
		end else if (eng.start) begin
			eng.busy <= 1'b1;
			unique case (eng.op)
				nmd_pkg::OP_READ: cnt_reg <= eng.multi ? 16'(`NMD_MREAD_CYC) : 16'(`NMD_READ_CYC);
				nmd_pkg::OP_PROG: cnt_reg <= 16'(`NMD_PROG_CYC);
				nmd_pkg::OP_ERASE: cnt_reg <= ERASE_CYCLES;
			endcase
		end else if (eng.busy) begin
			if (cnt_reg == 16'h0001)
				eng.busy <= 1'b0;
			cnt_reg <= cnt_reg - 16'h0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			op_reg <= nmd_pkg::OP_READ;
			mask_reg <= 2'h0;
			inj_reg <= 2'h0;
			errs_reg <= 4'h0;
			wp_reg <= 1'b0;
		end else if (eng.start) begin
			op_reg <= eng.op;
			mask_reg <= eng.dist_mask;
			inj_reg <= eng.fail_inj;
			errs_reg <= eng.ecc_errs;
			wp_reg <= eng.wp_ok;
		end
	end

	// results appear with the done pulse and stay until the next completion or an abort
	always_ff @(posedge i_clk) begin
		if (i_rst || eng.abort) begin
			eng.done <= 1'b0;
			eng.fail <= 2'h0;
			eng.ecc_uncorr <= 1'b0;
			eng.ecc_rewrite <= 1'b0;
		end else begin
			eng.done <= eng.busy && cnt_reg == 16'h0001;
			if (eng.busy && cnt_reg == 16'h0001) begin
				if (op_reg == nmd_pkg::OP_READ) begin
					// correction covers up to the limit; more errors are only flagged
					eng.ecc_uncorr <= errs_reg > `NMD_ECC_CORR_MAX;
					eng.ecc_rewrite <= errs_reg != 4'h0 && errs_reg <= `NMD_ECC_CORR_MAX;
					eng.fail <= (errs_reg > `NMD_ECC_CORR_MAX) ? mask_reg : 2'h0;
				end else begin
					// a low protect input inhibits the operation, which then reports fail
					eng.fail <= wp_reg ? (inj_reg & mask_reg) : mask_reg;
					eng.ecc_uncorr <= 1'b0;
					eng.ecc_rewrite <= 1'b0;
				end
			end
		end
	end
endmodule // nmd_engine

// >>> design/nmd_seq.sv
// nand command sequencer: decodes the strobed pin port and runs read, program and erase
// assumes pin strobes are slow against I_CLK (each level held at least four clocks)
// and a classic wishbone master on the register port
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ns
`include "nmd_cfg.svh"
module nmd_seq #(
	parameter logic [15:0] ERASE_CYCLES = 16'(`NMD_ERASE_CYC)
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [31:0] I_WB_DAT,
	input wire logic [3:0] I_WB_SEL,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	input wire logic I_CMD_LATCH,
	input wire logic I_ADDR_LATCH,
	input wire logic I_CHIP_EN_N,
	input wire logic I_WRITE_STROBE_N,
	input wire logic I_OUTPUT_STROBE_N,
	input wire logic I_WRITE_PROTECT_N,
	input wire logic [7:0] I_IO,
	output logic [7:0] O_IO,
	output logic O_IO_OE_N,
	output logic O_READY_BUSY_N,
	output logic O_READY_BUSY_N_OE_N
);
	nmd_eng_if eng();

	nmd_engine #(.ERASE_CYCLES(ERASE_CYCLES)) u_engine (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.eng(eng.eng)
	);

	// sector of a column: main field by 512-byte slices, spare by 16-byte slices
	function automatic logic [1:0] sector_of(input logic [11:0] col);
		if (col < `NMD_MAIN_BYTES)
			sector_of = col[`NMD_SECT_MAIN_SHIFT +: 2];
		else
			sector_of = col[`NMD_SECT_SPARE_SHIFT +: 2];
	endfunction

	function automatic logic denied(input logic [11:0] col);
		denied = col >= `NMD_PARITY_LO && col <= `NMD_PARITY_HI;
	endfunction

	// pin synchronisers; stage three only feeds the edge detectors
	logic [13:0] pin_s1_reg;
	logic [13:0] pin_s2_reg;
	logic [13:0] pin_s3_reg;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			pin_s1_reg <= 14'h003c;
			pin_s2_reg <= 14'h003c;
			pin_s3_reg <= 14'h003c;
		end else begin
			pin_s1_reg <= {I_IO, I_WRITE_PROTECT_N, I_OUTPUT_STROBE_N, I_WRITE_STROBE_N, I_CHIP_EN_N,
				I_ADDR_LATCH, I_CMD_LATCH};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	logic cle_s;
	logic ale_s;
	logic ce_n_s;
	logic re_n_s;
	logic wp_n_s;
	logic [7:0] io_s;
	logic we_rise;
	logic re_fall;
	logic cmd_we;
	logic addr_we;
	logic data_we;
	assign cle_s = pin_s2_reg[0];
	assign ale_s = pin_s2_reg[1];
	assign ce_n_s = pin_s2_reg[2];
	assign re_n_s = pin_s2_reg[4];
	assign wp_n_s = pin_s2_reg[5];
	assign io_s = pin_s2_reg[13:6];
	assign we_rise = pin_s2_reg[3] && !pin_s3_reg[3] && !ce_n_s;
	assign re_fall = !re_n_s && pin_s3_reg[4] && !ce_n_s;
	assign cmd_we = we_rise && cle_s && !ale_s;
	assign addr_we = we_rise && ale_s && !cle_s;
	assign data_we = we_rise && !ale_s && !cle_s;

	nmd_pkg::nmd_state_type state_reg;
	nmd_pkg::nmd_mode_type mode_reg;
	nmd_pkg::nmd_out_type out_sel_reg;
	logic [2:0] addr_cnt_reg;
	logic [7:0] addr_byte_reg [0:4];
	logic [11:0] col_reg;
	logic [1:0] slot_valid_reg;
	logic [10:0] slot_blk_reg [0:1];
	logic [5:0] slot_page_reg [0:1];
	logic [3:0] sect_mask_reg;
	logic [7:0] last_cmd_reg;
	logic [1:0] fail_reg;
	logic rewrite_reg;
	logic [31:0] ctrl_reg;

	// a row is complete after three bytes (row only) or five (column then row)
	logic commit_now;
	logic [16:0] row_now;
	logic [1:0] commit_mask;
	logic [1:0] slots_now;
	logic slot_clear;
	always_comb begin
		commit_now = (cmd_we || data_we) && state_reg == nmd_pkg::ST_ADDR &&
			(addr_cnt_reg == 3'h3 || addr_cnt_reg == 3'h5);
		if (addr_cnt_reg == 3'h3)
			row_now = {addr_byte_reg[2][0], addr_byte_reg[1], addr_byte_reg[0]};
		else
			row_now = {addr_byte_reg[4][0], addr_byte_reg[3], addr_byte_reg[2]};
		commit_mask = 2'h0;
		if (commit_now)
			commit_mask[row_now[`NMD_DIST_BIT]] = 1'b1;
		slots_now = slot_valid_reg | commit_mask;
		slot_clear = cmd_we && state_reg != nmd_pkg::ST_BUSY && (io_s == `NMD_CMD_READ ||
			io_s == `NMD_CMD_LOAD || io_s == `NMD_CMD_RESET ||
			(io_s == `NMD_CMD_SETUP && mode_reg != nmd_pkg::MODE_SETUP));
	end

	// each district keeps its own slot, so the order of arrival does not matter
	always_ff @(posedge I_CLK) begin
		if (I_RST || slot_clear) begin
			slot_valid_reg <= 2'h0;
		end else if (commit_now) begin
			slot_valid_reg <= slots_now;
			slot_blk_reg[row_now[`NMD_DIST_BIT]] <= row_now[16:6];
			slot_page_reg[row_now[`NMD_DIST_BIT]] <= row_now[5:0];
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST || cmd_we || data_we)
			addr_cnt_reg <= 3'h0;
		else if (addr_we && addr_cnt_reg != 3'h7)
			addr_cnt_reg <= addr_cnt_reg + 3'h1;
	end

	always_ff @(posedge I_CLK) begin
		if (addr_we && addr_cnt_reg < 3'h5)
			addr_byte_reg[addr_cnt_reg] <= io_s;
	end

	logic start_cmd;
	assign start_cmd = cmd_we && state_reg != nmd_pkg::ST_BUSY;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			state_reg <= nmd_pkg::ST_IDLE;
			mode_reg <= nmd_pkg::MODE_NONE;
			eng.start <= 1'b0;
			eng.abort <= 1'b0;
			eng.op <= nmd_pkg::OP_READ;
			eng.multi <= 1'b0;
			eng.dist_mask <= 2'h0;
		end else begin
			eng.start <= 1'b0;
			eng.abort <= 1'b0;
			if (cmd_we && io_s == `NMD_CMD_RESET) begin
				state_reg <= nmd_pkg::ST_IDLE;
				mode_reg <= nmd_pkg::MODE_NONE;
				eng.abort <= 1'b1;
			end else if (state_reg == nmd_pkg::ST_BUSY) begin
				if (eng.done) begin
					state_reg <= nmd_pkg::ST_IDLE;
					mode_reg <= nmd_pkg::MODE_NONE;
				end
			end else if (start_cmd) begin
				unique case (io_s)
					`NMD_CMD_READ: begin
						mode_reg <= nmd_pkg::MODE_READ;
						state_reg <= nmd_pkg::ST_ADDR;
					end
					`NMD_CMD_READ_GO: if ((mode_reg == nmd_pkg::MODE_READ || mode_reg == nmd_pkg::MODE_SETUP)
						&& slots_now != 2'h0) begin
						eng.start <= 1'b1;
						eng.op <= nmd_pkg::OP_READ;
						eng.multi <= mode_reg == nmd_pkg::MODE_SETUP;
						eng.dist_mask <= slots_now;
						state_reg <= nmd_pkg::ST_BUSY;
					end
					`NMD_CMD_LOAD: begin
						mode_reg <= nmd_pkg::MODE_PROG;
						state_reg <= nmd_pkg::ST_ADDR;
					end
					`NMD_CMD_LOAD2: if (state_reg == nmd_pkg::ST_WAIT2) begin
						mode_reg <= nmd_pkg::MODE_PROG2;
						state_reg <= nmd_pkg::ST_ADDR;
					end
					`NMD_CMD_COLCHG: if (state_reg == nmd_pkg::ST_DATA)
						state_reg <= nmd_pkg::ST_ADDR;
					`NMD_CMD_PROG_GO: if ((mode_reg == nmd_pkg::MODE_PROG || mode_reg == nmd_pkg::MODE_PROG2)
						&& slots_now != 2'h0) begin
						eng.start <= 1'b1;
						eng.op <= nmd_pkg::OP_PROG;
						eng.multi <= mode_reg == nmd_pkg::MODE_PROG2;
						eng.dist_mask <= slots_now;
						state_reg <= nmd_pkg::ST_BUSY;
					end
					`NMD_CMD_PROG_HOLD: if (mode_reg == nmd_pkg::MODE_PROG && slots_now != 2'h0)
						state_reg <= nmd_pkg::ST_WAIT2;
					`NMD_CMD_SETUP: begin
						mode_reg <= nmd_pkg::MODE_SETUP;
						state_reg <= nmd_pkg::ST_ADDR;
					end
					`NMD_CMD_ERASE_GO: if (mode_reg == nmd_pkg::MODE_SETUP && slots_now != 2'h0) begin
						eng.start <= 1'b1;
						eng.op <= nmd_pkg::OP_ERASE;
						eng.multi <= slots_now == 2'h3;
						eng.dist_mask <= slots_now;
						state_reg <= nmd_pkg::ST_BUSY;
					end
					default: ;
				endcase
			end else if (data_we && state_reg == nmd_pkg::ST_ADDR &&
				(mode_reg == nmd_pkg::MODE_PROG || mode_reg == nmd_pkg::MODE_PROG2)) begin
				state_reg <= nmd_pkg::ST_DATA;
			end
		end
	end

	// engine inputs sampled with the start pulse
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			eng.fail_inj <= 2'h0;
			eng.ecc_errs <= 4'h0;
			eng.wp_ok <= 1'b0;
		end else begin
			eng.fail_inj <= ctrl_reg[`NMD_CTRL_FAIL_LSB +: 2];
			eng.ecc_errs <= ctrl_reg[`NMD_CTRL_ECC_LSB +: 4];
			eng.wp_ok <= wp_n_s;
		end
	end

	// column pointer: second address byte, then one step per data byte in or out
	logic data_in_ok;
	assign data_in_ok = data_we && (state_reg == nmd_pkg::ST_DATA || state_reg == nmd_pkg::ST_ADDR) &&
		(mode_reg == nmd_pkg::MODE_PROG || mode_reg == nmd_pkg::MODE_PROG2);

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			col_reg <= 12'h000;
			sect_mask_reg <= 4'h0;
		end else begin
			if (cmd_we && io_s == `NMD_CMD_LOAD)
				sect_mask_reg <= 4'h0;
			if (addr_we && addr_cnt_reg == 3'h1)
				col_reg <= {io_s[3:0], addr_byte_reg[0]};
			else if (data_in_ok || (re_fall && out_sel_reg == nmd_pkg::OUT_PAGE))
				col_reg <= col_reg + 12'h001;
			if (data_in_ok && !denied(col_reg))
				sect_mask_reg[sector_of(col_reg)] <= 1'b1;
		end
	end

	// results of the last operation, kept until the next operation or reset
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			fail_reg <= 2'h0;
			rewrite_reg <= 1'b0;
			last_cmd_reg <= 8'h00;
		end else begin
			if (cmd_we)
				last_cmd_reg <= io_s;
			if (eng.done) begin
				fail_reg <= eng.fail;
				rewrite_reg <= eng.ecc_rewrite;
			end else if (eng.start || slot_clear) begin
				fail_reg <= 2'h0;
				rewrite_reg <= 1'b0;
			end
		end
	end

	logic ready;
	logic [7:0] stat_byte;
	logic [7:0] stat_dist_byte;
	always_comb begin
		ready = state_reg != nmd_pkg::ST_BUSY;
		stat_byte = 8'h00;
		stat_byte[`NMD_ST_FAIL] = |fail_reg;
		stat_byte[`NMD_ST_REWRITE] = rewrite_reg;
		stat_byte[`NMD_ST_READY_A] = ready;
		stat_byte[`NMD_ST_READY_B] = ready;
		stat_byte[`NMD_ST_WP] = wp_n_s;
		stat_dist_byte = 8'h00;
		stat_dist_byte[`NMD_ST_FAIL] = fail_reg[0] | fail_reg[1];
		stat_dist_byte[`NMD_ST_D0_FAIL] = fail_reg[0];
		stat_dist_byte[`NMD_ST_D1_FAIL] = fail_reg[1];
		stat_dist_byte[`NMD_ST_READY_A] = ready;
		stat_dist_byte[`NMD_ST_READY_B] = ready;
		stat_dist_byte[`NMD_ST_WP] = wp_n_s;
	end

	// output source: status after 70h/71h, page data once a read has finished
	always_ff @(posedge I_CLK) begin
		if (I_RST)
			out_sel_reg <= nmd_pkg::OUT_NONE;
		else if (cmd_we) begin
			if (io_s == `NMD_CMD_STAT)
				out_sel_reg <= nmd_pkg::OUT_STAT;
			else if (io_s == `NMD_CMD_STAT_DIST)
				out_sel_reg <= nmd_pkg::OUT_STAT_DIST;
			else if (state_reg != nmd_pkg::ST_BUSY || io_s == `NMD_CMD_RESET)
				out_sel_reg <= nmd_pkg::OUT_NONE;
		end else if (eng.done && eng.op == nmd_pkg::OP_READ)
			out_sel_reg <= nmd_pkg::OUT_PAGE;
	end

	// no cell array is held here: page bytes read as erased, parity columns as zero
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_IO <= 8'h00;
			O_IO_OE_N <= 1'b1;
			O_READY_BUSY_N <= 1'b0;
			O_READY_BUSY_N_OE_N <= 1'b1;
		end else begin
			O_IO_OE_N <= !(out_sel_reg != nmd_pkg::OUT_NONE && !ce_n_s && !re_n_s);
			O_READY_BUSY_N_OE_N <= ready;
			if (re_fall) begin
				unique case (out_sel_reg)
					nmd_pkg::OUT_STAT: O_IO <= stat_byte;
					nmd_pkg::OUT_STAT_DIST: O_IO <= stat_dist_byte;
					nmd_pkg::OUT_PAGE: O_IO <= denied(col_reg) ? 8'h00 : 8'hff;
					nmd_pkg::OUT_NONE: O_IO <= 8'h00;
				endcase
			end
		end
	end

	// wishbone slave: answers every access one cycle after the strobe
	logic wb_hit;
	assign wb_hit = I_WB_CYC && I_WB_STB && !O_WB_ACK;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_WB_ACK <= 1'b0;
			O_WB_DAT <= 32'h0000_0000;
			ctrl_reg <= `NMD_CTRL_RESET;
		end else begin
			O_WB_ACK <= wb_hit;
			if (wb_hit && I_WB_WE && I_WB_ADR == `NMD_WB_CTRL) begin
				for (int b = 0; b < 4; b++)
					if (I_WB_SEL[b])
						ctrl_reg[b*8 +: 8] <= I_WB_DAT[b*8 +: 8];
			end
			if (wb_hit && !I_WB_WE) begin
				unique case (I_WB_ADR)
					`NMD_WB_CTRL: O_WB_DAT <= ctrl_reg;
					`NMD_WB_STATUS: O_WB_DAT <= {9'h000, state_reg, 4'h0, stat_dist_byte, stat_byte};
					`NMD_WB_ADDR: O_WB_DAT <= {col_reg, 1'b0, slot_blk_reg[0], slot_page_reg[0], slot_valid_reg};
					`NMD_WB_SECT: O_WB_DAT <= {16'h0000, last_cmd_reg, 4'h0, sect_mask_reg};
					default: O_WB_DAT <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // nmd_seq

// >>> tb/nmd_seq_asserts.sv
// port checker for the nand command sequencer
// assumes it is bound to nmd_seq and that pin strobes are held four clocks or more
`timescale 1ns/1ns
module nmd_seq_asserts #(
	parameter logic [15:0] ERASE_CYCLES = 16'h0032
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic O_WB_ACK,
	input wire logic I_CMD_LATCH,
	input wire logic I_CHIP_EN_N,
	input wire logic I_WRITE_STROBE_N,
	input wire logic I_OUTPUT_STROBE_N,
	input wire logic I_WRITE_PROTECT_N,
	input wire logic [7:0] I_IO,
	input wire logic [7:0] O_IO,
	input wire logic O_IO_OE_N,
	input wire logic O_READY_BUSY_N,
	input wire logic O_READY_BUSY_N_OE_N
);
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	logic ws_q;
	logic [7:0] cmd_reg;
	logic cmd_go;
	logic rdy;
	// a command counts on the strobe rise, the edge on which the device takes it
	assign cmd_go = I_WRITE_STROBE_N && !ws_q && I_CMD_LATCH && !I_CHIP_EN_N;
	assign rdy = O_READY_BUSY_N_OE_N;
	always_ff @(posedge I_CLK) begin
		ws_q <= I_WRITE_STROBE_N;
	end
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cmd_reg <= 8'h00;
		end else if (cmd_go) begin
			cmd_reg <= I_IO;
		end
	end
	AST_ACK_NEXT: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
		else $error("ack late");
	AST_RB_OPEN_DRAIN: assert property (O_READY_BUSY_N == 1'b0)
		else $error("busy line driven high");
	AST_RESET_READY: assert property ($fell(I_RST) |-> O_IO_OE_N && rdy && !O_WB_ACK)
		else $error("not idle after reset");
	AST_BUSY_MIN: assert property ($fell(rdy) && I_WRITE_PROTECT_N |=> !rdy [*4])
		else $error("busy too short");
	AST_OUT_AFTER_RE: assert property ($fell(O_IO_OE_N) |-> !$past(I_OUTPUT_STROBE_N, 2))
		else $error("port driven without read strobe");
	AST_ST71_OR: assert property (!O_IO_OE_N && cmd_reg == 8'h71 |-> O_IO[0] == (O_IO[1] | O_IO[2]))
		else $error("fail bit not or of districts");
	AST_ST71_BITS: assert property (!O_IO_OE_N && cmd_reg == 8'h71 |->
		O_IO[7] == I_WRITE_PROTECT_N && O_IO[6] == O_IO[5])
		else $error("status protect or ready bits wrong");
	AST_ERASE_GO: assert property (cmd_go && I_IO == 8'hd0 && cmd_reg == 8'h60 &&
		rdy && I_WRITE_PROTECT_N |-> ##[1:5] !rdy)
		else $error("erase did not start");
	AST_NO_ERASE: assert property (cmd_go && I_IO == 8'hd0 && cmd_reg != 8'h60 && rdy |=> rdy [*8])
		else $error("erase started without setup");
	AST_PROG_GO: assert property (cmd_go && I_IO == 8'h10 &&
		cmd_reg inside {8'h80, 8'h81, 8'h85} && rdy && I_WRITE_PROTECT_N |-> ##[1:5] !rdy)
		else $error("program did not start");
	AST_READ_GO: assert property (cmd_go && I_IO == 8'h30 &&
		cmd_reg inside {8'h00, 8'h60} && rdy |-> ##[1:5] !rdy)
		else $error("read did not go busy");
	AST_FF_READY: assert property (cmd_go && I_IO == 8'hff |-> ##[1:8] rdy)
		else $error("reset command left device busy");
	cover property (cmd_go && I_IO == 8'hd0 && cmd_reg == 8'h60);
	cover property (!O_IO_OE_N && cmd_reg == 8'h71);
	cover property (cmd_go && I_IO == 8'h10 && cmd_reg == 8'h85);
endmodule // nmd_seq_asserts

// >>> tb/nmd_host.sv
// external host controller driving the strobed pin port of the sequencer
// assumes one clock; every strobe level is held hold clocks
`timescale 1ns/1ns
module nmd_host (
	input wire logic i_clk,
	input wire logic [7:0] i_dev_io,
	input wire logic i_dev_oe_n,
	input wire logic i_rb_n,
	input wire logic i_rb_oe_n,
	output logic o_cle,
	output logic o_ale,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_re_n,
	output logic o_wp_n,
	output logic [7:0] o_io,
	output logic o_rb
);
	logic [7:0] drv;
	logic drv_en;
	int hold = 5;
	// a released port shows the inverse of the last byte so a stale value never passes
	assign o_io = !i_dev_oe_n ? i_dev_io : (drv_en ? drv : ~drv);
	assign o_rb = i_rb_oe_n ? 1'b1 : i_rb_n;
	initial begin
		{o_cle, o_ale, drv_en, drv} = '0;
		{o_ce_n, o_we_n, o_re_n, o_wp_n} = '1;
	end
	task automatic put(input logic cl, input logic al, input logic [7:0] b);
		@(posedge i_clk);
		o_ce_n <= 1'b0;
		o_cle <= cl;
		o_ale <= al;
		drv <= b;
		drv_en <= 1'b1;
		o_we_n <= 1'b0;
		repeat (hold) @(posedge i_clk);
		o_we_n <= 1'b1;
		repeat (hold) @(posedge i_clk);
		drv_en <= 1'b0;
		o_cle <= 1'b0;
		o_ale <= 1'b0;
	endtask
	task automatic col(input logic [11:0] c);
		put(0, 1, c[7:0]);
		put(0, 1, {4'h0, c[11:8]});
	endtask
	task automatic row(input logic [16:0] w);
		put(0, 1, w[7:0]);
		put(0, 1, w[15:8]);
		put(0, 1, {7'h00, w[16]});
	endtask
	task automatic rd(output logic [7:0] b);
		@(posedge i_clk);
		o_re_n <= 1'b0;
		repeat (hold) @(posedge i_clk);
		b = o_io;
		o_re_n <= 1'b1;
		repeat (hold) @(posedge i_clk);
	endtask
	task automatic stat(input logic [7:0] c, output logic [7:0] b);
		put(1, 0, c);
		rd(b);
	endtask
	task automatic wait_rdy(output bit ok);
		ok = 0;
		for (int n = 0; n < 8000 && !ok; n++) begin
			@(posedge i_clk);
			ok = o_rb;
		end
	endtask
	task automatic run(input logic [1:0] op, input logic multi, input logic [10:0] a, input logic [10:0] b,
		input logic [5:0] pg);
		put(1, 0, op == 2'h1 ? 8'h80 : (op == 2'h0 && !multi ? 8'h00 : 8'h60));
		if (op == 2'h1 || (op == 2'h0 && !multi)) col(12'h000);
		row({a, pg});
		if (op == 2'h1) put(0, 0, 8'h5a);
		if (multi) begin
			if (op == 2'h1) begin
				put(1, 0, 8'h11);
				put(1, 0, 8'h70);
				put(1, 0, 8'h81);
				col(12'h000);
			end else begin
				put(1, 0, 8'h60);
			end
			row({b, pg});
			if (op == 2'h1) put(0, 0, 8'h5a);
		end
		put(1, 0, op == 2'h0 ? 8'h30 : (op == 2'h1 ? 8'h10 : 8'hd0));
	endtask
endmodule // nmd_host

// >>> tb/nmd_seq_test.sv
// self-checking bench for the nand command sequencer
// assumes nmd_host on the pin port and a wishbone master in this module
`timescale 1ns/1ns
module nmd_seq_test;
	localparam logic [15:0] ERASE_CYCLES = 16'h0032;
	typedef struct packed {
		logic [1:0] op;
		logic multi;
		logic [10:0] blk_a;
		logic [10:0] blk_b;
		logic [5:0] page;
		logic [1:0] inj;
		logic [3:0] ecc;
	} nmd_row_type;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat_w = 32'h0;
	logic [3:0] wb_sel = 4'hf;
	logic [3:0] lanes = 4'hf;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic cle, ale, ce_n, we_n, re_n, wp_n, rb, dev_oe_n, rb_n, rb_oe_n;
	logic [7:0] io;
	logic [7:0] dev_io;
	logic [7:0] v;
	logic [31:0] q;
	logic [1:0] sel;
	logic [1:0] f;
	bit ok;
	int miscompares = 0;
	int samples_checked = 0;
	nmd_row_type r;
	nmd_row_type rows [7] = '{
		'{2'h2, 1'b0, 11'h004, 11'h000, 6'h00, 2'h1, 4'h0},
		'{2'h2, 1'b0, 11'h007, 11'h000, 6'h00, 2'h1, 4'h0},
		'{2'h2, 1'b1, 11'h7ff, 11'h002, 6'h00, 2'h2, 4'h0},
		'{2'h1, 1'b0, 11'h000, 11'h000, 6'h05, 2'h0, 4'h0},
		'{2'h1, 1'b1, 11'h7fe, 11'h001, 6'h3f, 2'h3, 4'h0},
		'{2'h0, 1'b1, 11'h003, 11'h00a, 6'h01, 2'h0, 4'h9},
		'{2'h0, 1'b0, 11'h00b, 11'h000, 6'h02, 2'h0, 4'h8}
	};
	always #50 clk = ~clk;
	nmd_seq #(.ERASE_CYCLES(ERASE_CYCLES)) u_nmd_seq (.I_CLK(clk), .I_RST(rst), .I_WB_CYC(wb_cyc), .I_WB_STB(wb_stb),
		.I_WB_WE(wb_we), .I_WB_ADR(wb_adr), .I_WB_DAT(wb_dat_w), .I_WB_SEL(wb_sel), .O_WB_DAT(wb_dat_r),
		.O_WB_ACK(wb_ack), .I_CMD_LATCH(cle), .I_ADDR_LATCH(ale), .I_CHIP_EN_N(ce_n), .I_WRITE_STROBE_N(we_n),
		.I_OUTPUT_STROBE_N(re_n), .I_WRITE_PROTECT_N(wp_n), .I_IO(io), .O_IO(dev_io), .O_IO_OE_N(dev_oe_n),
		.O_READY_BUSY_N(rb_n), .O_READY_BUSY_N_OE_N(rb_oe_n));
	nmd_host u_nmd_host (.i_clk(clk), .i_dev_io(dev_io), .i_dev_oe_n(dev_oe_n), .i_rb_n(rb_n), .i_rb_oe_n(rb_oe_n),
		.o_cle(cle), .o_ale(ale), .o_ce_n(ce_n), .o_we_n(we_n), .o_re_n(re_n), .o_wp_n(wp_n), .o_io(io), .o_rb(rb));
	task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		samples_checked++;
		if ((got & m) !== (exp & m)) begin
			miscompares++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		wb_sel <= lanes;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		rd = wb_dat_r;
		if (n >= 20) miscompares++;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		wb(1'b1, 8'h00, 32'h0000_0903, q);
		wb(1'b0, 8'h00, 32'h0, q);
		chk(q, 32'h0000_0903, 32'h0000_0f03);
		// only lane 0 may change: the ecc count in lane 1 must survive
		lanes = 4'h1;
		wb(1'b1, 8'h00, 32'h0000_0502, q);
		lanes = 4'hf;
		wb(1'b0, 8'h00, 32'h0, q);
		chk(q, 32'h0000_0902, 32'h0000_0fff);
		wb(1'b0, 8'h20, 32'h0, q);
		chk(q, 32'h0, 32'hffff_ffff);
		for (int i = 0; i < 7; i++) begin
			r = rows[i];
			sel = r.multi ? ((2'h1 << r.blk_a[0]) | (2'h1 << r.blk_b[0])) : (2'h1 << r.blk_a[0]);
			f = r.op == 2'h0 ? {2{r.ecc > 4'h8}} : r.inj & sel;
			wb(1'b1, 8'h00, {20'h0, r.ecc, 6'h0, r.inj}, q);
			u_nmd_host.run(r.op, r.multi, r.blk_a, r.blk_b, r.page);
			u_nmd_host.wait_rdy(ok);
			chk(32'(ok), 32'h1, 32'h1);
			u_nmd_host.stat(8'h70, v);
			chk(32'(v), {24'h0, 7'h70, |f}, r.op == 2'h0 ? 32'hf7 : 32'hff);
			if (r.op != 2'h0) begin
				u_nmd_host.stat(8'h71, v);
				chk(32'(v), {24'h0, 5'h1c, f, |f}, 32'he7);
			end
		end
		u_nmd_host.put(1, 0, 8'h70);
		u_nmd_host.put(1, 0, 8'hd0);
		chk(32'(rb), 32'h1, 32'h1);
		u_nmd_host.put(1, 0, 8'h60);
		u_nmd_host.row(17'h00400);
		u_nmd_host.put(1, 0, 8'h60);
		u_nmd_host.row(17'h00440);
		u_nmd_host.put(1, 0, 8'hff);
		u_nmd_host.put(1, 0, 8'hd0);
		chk(32'(rb), 32'h1, 32'h1);
		u_nmd_host.run(2'h2, 1'b0, 11'h004, 11'h000, 6'h00);
		u_nmd_host.put(1, 0, 8'hff);
		repeat (5) @(posedge clk);
		chk(32'(rb), 32'h1, 32'h1);
		// slow host: wider strobes across a column change into the spare field
		u_nmd_host.hold = 9;
		u_nmd_host.put(1, 0, 8'h80);
		u_nmd_host.col(12'h000);
		u_nmd_host.row(17'h00180);
		u_nmd_host.put(0, 0, 8'h11);
		u_nmd_host.put(1, 0, 8'h85);
		u_nmd_host.col(12'h800);
		u_nmd_host.put(0, 0, 8'h22);
		u_nmd_host.put(1, 0, 8'h10);
		chk(32'(rb), 32'h0, 32'h1);
		u_nmd_host.wait_rdy(ok);
		wb(1'b0, 8'h08, 32'h0, q);
		chk(q, 32'h8010_0601, 32'hffff_ffff);
		wb(1'b0, 8'h0c, 32'h0, q);
		chk(q, 32'h0000_1001, 32'h0000_ff0f);
		u_nmd_host.stat(8'h70, v);
		chk(32'(v), 32'he0, 32'hff);
		u_nmd_host.hold = 5;
		u_nmd_host.o_wp_n <= 1'b0;
		u_nmd_host.run(2'h2, 1'b0, 11'h008, 11'h000, 6'h00);
		u_nmd_host.wait_rdy(ok);
		u_nmd_host.stat(8'h71, v);
		chk(32'(v), 32'h63, 32'he7);
		u_nmd_host.o_wp_n <= 1'b1;
		u_nmd_host.run(2'h1, 1'b0, 11'h00c, 11'h000, 6'h01);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(32'(rb), 32'h1, 32'h1);
		print_verdict();
	end
endmodule // nmd_seq_test
bind nmd_seq nmd_seq_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) u_nmd_seq_asserts (.I_CLK, .I_RST, .I_WB_CYC, .I_WB_STB,
	.O_WB_ACK, .I_CMD_LATCH, .I_CHIP_EN_N, .I_WRITE_STROBE_N, .I_OUTPUT_STROBE_N, .I_WRITE_PROTECT_N, .I_IO, .O_IO,
	.O_IO_OE_N, .O_READY_BUSY_N, .O_READY_BUSY_N_OE_N);
